/* link_regs_pkg.sv */
package link_regs_pkg;

    // ****************************************************************
    // configuration map
    // ****************************************************************
    localparam logic [11:0] LINK_CTRL_OFS = 12'h0a0;
    localparam logic [11:0] LINK_STAT_OFS = 12'h0a2;
    localparam int DWORD_LSB = 2;
    localparam int STAT_LSB = 16;

    // ****************************************************************
    // control field positions and values
    // ****************************************************************
    localparam int CLK_PM_BIT = 8;
    localparam int EXT_SYNC_BIT = 7;
    localparam int COMMON_CLK_BIT = 6;
    localparam int RETRAIN_BIT = 5;
    localparam int LINK_OFF_BIT = 4;
    localparam int ASPM_LSB = 0;
    localparam int ASPM_MSB = 1;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_RW_MASK = 16'h01d3;

    // ****************************************************************
    // status field positions and values
    // ****************************************************************
    localparam int DL_ACTIVE_BIT = 13;
    localparam int SLOT_CLK_BIT = 12;
    localparam int TRAINING_BIT = 11;
    localparam int WIDTH_LSB = 4;
    localparam int WIDTH_MSB = 9;
    localparam int SPEED_LSB = 0;
    localparam int SPEED_MSB = 3;
    localparam logic [5:0] WIDTH_X1 = 6'h01;
    localparam logic [3:0] SPEED_2G5 = 4'h1;
    localparam logic [15:0] STAT_RESET = 16'h1011;

    // ****************************************************************
    // latency arithmetic
    // ****************************************************************
    localparam logic [2:0] LAT_MAX = 3'h7;
    localparam logic [2:0] CLKPM_L1_EXTRA = 3'h1;

    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
        logic [3:0] byteEn;
        logic [31:0] wrData;
    } cfg_req_t;

    typedef struct packed {
        logic ltssmCfgRecovery;
        logic dlActive;
        logic linkActRptCap;
    } link_state_t;

endpackage

/* downstream_link_ctrl_status_regs.sv */
module downstream_link_ctrl_status_regs
    import link_regs_pkg::*;
#(
    parameter logic [2:0] L1_EXTRA = CLKPM_L1_EXTRA
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // configuration access
    input wire cfg_req_t cfgReq,
    output logic cfgHit,
    output logic cfgAck,
    output logic [31:0] cfgRdData,
    // link state from training logic
    input wire link_state_t linkState,
    // exit latencies from the latency register
    input wire logic [2:0] l0sLatAsync,
    input wire logic [2:0] l0sLatCommon,
    input wire logic [2:0] l1LatAsync,
    input wire logic [2:0] l1LatCommon,
    // controls to the link
    output logic clockPmEnable,
    output logic extendedSync,
    output logic commonClockCfg,
    output logic linkOff,
    output logic [1:0] activeStatePmControl,
    output logic retrainRequest,
    // reported latencies
    output logic [2:0] l0sExitLatency,
    output logic [2:0] endpointL1ExitLatency
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [15:0] ctrl;
        logic training;
        logic ltssmPrev;
        logic retrain;
        logic ack;
        logic [31:0] rdData;
        logic [2:0] l0sLat;
        logic [2:0] l1Lat;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic [15:0] ctrlWrMask;
    logic [15:0] ctrlRead;
    logic [15:0] statRead;
    logic [2:0] l1Base;
    logic [3:0] l1Sum;
    logic wrHit;
    logic rdHit;
    logic retrainWr;
    logic cfgExit;

    assign cfgHit = cfgReq.valid
        && (cfgReq.addr[11:DWORD_LSB] == LINK_CTRL_OFS[11:DWORD_LSB]);
    assign wrHit = cfgHit && cfgReq.write;
    assign rdHit = cfgHit && !cfgReq.write;
    // only the low byte lane reaches the retrain bit
    assign retrainWr = wrHit && cfgReq.byteEn[0]
        && cfgReq.wrData[RETRAIN_BIT];
    // falling edge of the Configuration/Recovery indication
    assign cfgExit = st_r.ltssmPrev && !linkState.ltssmCfgRecovery;

    // ****************************************************************
    // read values
    // ****************************************************************
    always_comb
    begin
        // reserved, boundary and retrain bits stay zero on reads
        ctrlRead = st_r.ctrl & CTRL_RW_MASK;
        statRead = '0;
        statRead[DL_ACTIVE_BIT] = linkState.linkActRptCap
            && linkState.dlActive;
        statRead[SLOT_CLK_BIT] = 1'b1;
        statRead[TRAINING_BIT] = st_r.training;
        statRead[WIDTH_MSB:WIDTH_LSB] = WIDTH_X1;
        statRead[SPEED_MSB:SPEED_LSB] = SPEED_2G5;
    end

    // ****************************************************************
    // latency selection
    // ****************************************************************
    always_comb
    begin
        l1Base = st_r.ctrl[COMMON_CLK_BIT] ? l1LatCommon : l1LatAsync;
        // saturate rather than wrap, a wrapped code would look faster
        l1Sum = {1'b0, l1Base} + {1'b0, L1_EXTRA};
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        st_nxt = st_r;
        ctrlWrMask = '0;
        if (wrHit && cfgReq.byteEn[0])
        begin
            ctrlWrMask[7:0] = CTRL_RW_MASK[7:0];
        end
        if (wrHit && cfgReq.byteEn[1])
        begin
            ctrlWrMask[15:8] = CTRL_RW_MASK[15:8];
        end
        // status lanes are read-only; writes there fall away
        st_nxt.ctrl = (st_r.ctrl & ~ctrlWrMask)
            | (cfgReq.wrData[15:0] & ctrlWrMask);
        st_nxt.retrain = retrainWr;
        st_nxt.ltssmPrev = linkState.ltssmCfgRecovery;
        // a fresh request wins over the exit of an older session
        if (retrainWr || linkState.ltssmCfgRecovery)
        begin
            st_nxt.training = 1'b1;
        end
        else if (cfgExit)
        begin
            st_nxt.training = 1'b0;
        end
        st_nxt.ack = cfgHit;
        if (rdHit)
        begin
            st_nxt.rdData = {statRead, ctrlRead};
        end
        st_nxt.l0sLat = st_r.ctrl[COMMON_CLK_BIT]
            ? l0sLatCommon : l0sLatAsync;
        if (st_r.ctrl[CLK_PM_BIT])
        begin
            st_nxt.l1Lat = l1Sum[3] ? LAT_MAX : l1Sum[2:0];
        end
        else
        begin
            st_nxt.l1Lat = l1Base;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_r <= '0;
            st_r.ctrl <= CTRL_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign cfgAck = st_r.ack;
    assign cfgRdData = st_r.rdData;
    assign clockPmEnable = st_r.ctrl[CLK_PM_BIT];
    assign extendedSync = st_r.ctrl[EXT_SYNC_BIT];
    assign commonClockCfg = st_r.ctrl[COMMON_CLK_BIT];
    assign linkOff = st_r.ctrl[LINK_OFF_BIT];
    assign activeStatePmControl = st_r.ctrl[ASPM_MSB:ASPM_LSB];
    assign retrainRequest = st_r.retrain;
    assign l0sExitLatency = st_r.l0sLat;
    assign endpointL1ExitLatency = st_r.l1Lat;

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence lowLaneWrite;
        wrHit && cfgReq.byteEn[0];
    endsequence

    sequence highLaneWrite;
        wrHit && cfgReq.byteEn[1];
    endsequence

    sequence singlePulse;
        retrainRequest ##1 !retrainRequest;
    endsequence

    reserved_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        $past(rdHit) |-> cfgRdData[15:9] == '0 && !cfgRdData[3]
        && !cfgRdData[2])
        else $error("reserved control bits read nonzero");

    clkpm_store_a: assert property (@(posedge clk) disable iff (!reset_n)
        highLaneWrite |=> clockPmEnable == $past(cfgReq.wrData[CLK_PM_BIT]))
        else $error("clock pm enable not stored");

    l1_latency_a: assert property (@(posedge clk) disable iff (!reset_n)
        clockPmEnable && l1Base != LAT_MAX
        |=> endpointL1ExitLatency > $past(l1Base))
        else $error("l1 latency not raised");

    // a second retrain write right behind the first may renew the pulse
    retrain_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
        lowLaneWrite ##0 cfgReq.wrData[RETRAIN_BIT] ##1 !retrainWr
        |-> singlePulse)
        else $error("retrain pulse wrong");

    retrain_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        cfgAck |-> !cfgRdData[RETRAIN_BIT])
        else $error("retrain bit reads one");

    link_off_a: assert property (@(posedge clk) disable iff (!reset_n)
        lowLaneWrite ##1 (rdHit && !(wrHit && cfgReq.byteEn[0]))
        |=> cfgRdData[LINK_OFF_BIT]
        == $past(cfgReq.wrData[LINK_OFF_BIT], 2))
        else $error("link off readback wrong");

    aspm_store_a: assert property (@(posedge clk) disable iff (!reset_n)
        lowLaneWrite |=> activeStatePmControl
        == $past(cfgReq.wrData[ASPM_MSB:ASPM_LSB]))
        else $error("aspm control not stored");

    status_fixed_a: assert property (@(posedge clk) disable iff (!reset_n)
        $past(rdHit) |-> cfgRdData[STAT_LSB+SLOT_CLK_BIT]
        && cfgRdData[STAT_LSB+WIDTH_MSB:STAT_LSB+WIDTH_LSB] == WIDTH_X1
        && cfgRdData[STAT_LSB+SPEED_MSB:STAT_LSB+SPEED_LSB] == SPEED_2G5
        && cfgRdData[31:30] == '0)
        else $error("fixed status fields wrong");

    training_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
        cfgExit && !retrainWr && !linkState.ltssmCfgRecovery
        |=> !statRead[TRAINING_BIT])
        else $error("training bit not cleared");

    dll_active_a: assert property (@(posedge clk) disable iff (!reset_n)
        rdHit |=> cfgRdData[STAT_LSB+DL_ACTIVE_BIT]
        == $past(linkState.linkActRptCap && linkState.dlActive))
        else $error("dl active flag wrong");

endmodule // downstream_link_ctrl_status_regs

/* testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import link_regs_pkg::*;

    // ****************************************************************
    // stimulus and observation
    // ****************************************************************
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    cfg_req_t cfgReq = '0;
    link_state_t linkState = '0;
    logic [2:0] l0sLatAsync = 3'h2;
    logic [2:0] l0sLatCommon = 3'h5;
    logic [2:0] l1LatAsync = 3'h3;
    logic [2:0] l1LatCommon = 3'h6;
    logic cfgHit, cfgAck, retrainRequest;
    logic [31:0] cfgRdData;
    logic clockPmEnable, extendedSync, commonClockCfg, linkOff;
    logic [1:0] activeStatePmControl;
    logic [2:0] l0sExitLatency, endpointL1ExitLatency;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    always #10 clk = ~clk;

    downstream_link_ctrl_status_regs uut (
        .clk(clk),
        .reset_n(reset_n),
        .cfgReq(cfgReq),
        .cfgHit(cfgHit),
        .cfgAck(cfgAck),
        .cfgRdData(cfgRdData),
        .linkState(linkState),
        .l0sLatAsync(l0sLatAsync),
        .l0sLatCommon(l0sLatCommon),
        .l1LatAsync(l1LatAsync),
        .l1LatCommon(l1LatCommon),
        .clockPmEnable(clockPmEnable),
        .extendedSync(extendedSync),
        .commonClockCfg(commonClockCfg),
        .linkOff(linkOff),
        .activeStatePmControl(activeStatePmControl),
        .retrainRequest(retrainRequest),
        .l0sExitLatency(l0sExitLatency),
        .endpointL1ExitLatency(endpointL1ExitLatency)
    );

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic results;
        $display("checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // request stays up so back-to-back calls keep one assignment per step
    task automatic acc(input logic wr, input logic [11:0] a,
                       input logic [3:0] be, input logic [31:0] d);
        cfgReq = '{1'b1, wr, a, be, d};
        @(posedge clk);
        #1;
    endtask

    task automatic idle;
        cfgReq.valid = 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic rd(input logic [31:0] exp);
        acc(1'b0, LINK_CTRL_OFS, 4'hf, 32'h0);
        chk("ack", 32'h1, {31'h0, cfgAck});
        chk("read data", exp, cfgRdData);
        idle();
    endtask

    task automatic ctl(input logic [5:0] exp);
        chk("controls", {26'h0, exp}, {26'h0, clockPmEnable, extendedSync,
            commonClockCfg, linkOff, activeStatePmControl});
    endtask

    task automatic lat(input logic [2:0] l0s, input logic [2:0] l1);
        chk("latencies", {26'h0, l0s, l1},
            {26'h0, l0sExitLatency, endpointL1ExitLatency});
    endtask

    // ****************************************************************
    // timeout and main sequence
    // ****************************************************************
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            num_errors++;
            results();
        end
    end

    initial
    begin
        repeat (2) @(posedge clk);
        #1 reset_n = 1'b1;
        ctl(6'h00);
        rd(32'h1011_0000);
        linkState.ltssmCfgRecovery = 1'b1;
        acc(1'b1, LINK_CTRL_OFS, 4'h3, 32'hffff_ffff);
        chk("write ack", 32'h1, {31'h0, cfgAck});
        chk("retrain", 32'h1, {31'h0, retrainRequest});
        ctl(6'h3f);
        idle();
        chk("retrain", 32'h0, {31'h0, retrainRequest});
        lat(3'h5, 3'h7);
        rd(32'h1811_01d3);
        linkState.ltssmCfgRecovery = 1'b0;
        idle();
        rd(32'h1011_01d3);
        linkState.dlActive = 1'b1;
        acc(1'b1, LINK_CTRL_OFS, 4'h3, 32'h0000_0110);
        idle();
        lat(3'h2, 3'h4);
        rd(32'h1011_0110);
        linkState.linkActRptCap = 1'b1;
        idle();
        rd(32'h3011_0110);
        acc(1'b1, LINK_CTRL_OFS, 4'h2, 32'h0);
        idle();
        lat(3'h2, 3'h3);
        rd(32'h3011_0010);
        for (int i = 0; i < 4; i++)
        begin
            acc(1'b1, LINK_CTRL_OFS, 4'h1, i);
            ctl(i[5:0]);
            rd({16'h3011, 14'h0, i[1:0]});
        end
        l1LatCommon = 3'h7;
        acc(1'b1, LINK_CTRL_OFS, 4'h3, 32'h0000_0140);
        idle();
        lat(3'h5, 3'h7);
        acc(1'b1, LINK_CTRL_OFS, 4'hc, 32'h0000_ffff);
        idle();
        rd(32'h3011_0140);
        acc(1'b0, LINK_STAT_OFS, 4'hc, 32'h0);
        chk("status read", 32'h3011_0140, cfgRdData);
        idle();
        cfgReq = '{1'b1, 1'b0, 12'h0a4, 4'hf, 32'h0};
        #1 chk("hit", 32'h0, {31'h0, cfgHit});
        @(posedge clk);
        #1 chk("ack", 32'h0, {31'h0, cfgAck});
        chk("held data", 32'h3011_0140, cfgRdData);
        acc(1'b1, 12'h0a4, 4'hf, 32'h0);
        idle();
        rd(32'h3011_0140);
        // second reset in mid-run
        reset_n = 1'b0;
        #20 ctl(6'h00);
        chk("read data", 32'h0, cfgRdData);
        reset_n = 1'b1;
        rd(32'h3011_0000);
        results();
    end
endmodule // testbench
